// ==== shared/pwk_cfg.svh ====
// register offsets, field positions and reset values of the wake block
`ifndef PWK_CFG_SVH
`define PWK_CFG_SVH
`define PWK_IDX_FDD_RATE     8'hC2
`define PWK_IDX_SER1_FIFO    8'hC3
`define PWK_IDX_SER2_FIFO    8'hC4
`define PWK_IDX_WAKE_CTRL    8'hC5
`define PWK_IDX_WAKE_PEND    8'hC6
`define PWK_IDX_SRC_STATUS   8'hC7
`define PWK_IDX_SRC_ENABLE   8'hC8
`define PWK_FDD_RATE_MASK    8'hDF
`define PWK_SER_FIFO_MASK    8'hCF
`define PWK_CTRL_MASK        8'h01
`define PWK_PEND_MASK        8'h01
`define PWK_SRC_MASK         8'h1E
`define PWK_BIT_PORT2_RING   1
`define PWK_BIT_PORT1_RING   2
`define PWK_BIT_KEYBOARD     3
`define PWK_BIT_MOUSE        4
`define PWK_RST_BYTE         8'h00
`define PWK_RST_WORD         32'h0000_0000
`endif

// ==== shared/pwk_pkg.sv ====
// shared types of the wake block
package pwk_pkg;
	typedef logic [7:0] pwk_byte_t;
	typedef logic [31:0] pwk_word_t;
endpackage

// ==== rtl/pwk_top.sv ====
// wake logic, wake status registers and read-only shadows on avalon-mm
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pwk_cfg.svh"
module pwk_top (
	input  wire logic                SYS_CLK,
	input  wire logic                NRST,
	input  wire logic                STBY_NRST,
	input  wire logic [9:0]          AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	output logic      [31:0]         AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	input  wire logic [7:0]          FDD_RATE_CTRL,
	input  wire logic [7:0]          SER1_FIFO_CTRL,
	input  wire logic [7:0]          SER2_FIFO_CTRL,
	input  wire logic                PORT1_RING_WAKE,
	input  wire logic                PORT2_RING_WAKE,
	input  wire logic                KEYBOARD_WAKE,
	input  wire logic                MOUSE_WAKE,
	output logic                     WAKE_REQUEST_N,
	output logic                     WAKE_REQUEST_OE,
	output logic                     IRQ
);
	// reset synchronisers, main and standby domains
	logic        main_s1_q, main_s2_q;
	logic        stby_s1_q, stby_s2_q;
	wire  logic  rst_n  = main_s2_q;
	wire  logic  srst_n = stby_s2_q;

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			main_s1_q <= 1'b0;
			main_s2_q <= 1'b0;
		end else begin
			main_s1_q <= 1'b1;
			main_s2_q <= main_s1_q;
		end
	end

	// standby reset synchroniser; it acts on the standby copy only and leaves the main copy alone
	always_ff @(posedge SYS_CLK or negedge STBY_NRST) begin
		if (!STBY_NRST) begin
			stby_s1_q <= 1'b0;
			stby_s2_q <= 1'b0;
		end else begin
			stby_s1_q <= 1'b1;
			stby_s2_q <= stby_s1_q;
		end
	end

	// wake pin synchronisers; first stage read only by second
	logic [4:0]  wk_s1_q, wk_s2_q;
	wire  logic [4:0] wk_pins = {MOUSE_WAKE, KEYBOARD_WAKE, PORT1_RING_WAKE,
		PORT2_RING_WAKE, 1'b0};

	always_ff @(posedge SYS_CLK or negedge srst_n) begin
		if (!srst_n) begin
			wk_s1_q <= 5'h00;
			wk_s2_q <= 5'h00;
		end else begin
			wk_s1_q <= wk_pins;
			wk_s2_q <= wk_s1_q;
		end
	end

	// bus handshake: one wait cycle, then answer
	logic              wait_q;
	pwk_pkg::pwk_word_t rdata_q;
	wire  logic        req    = AVS_READ | AVS_WRITE;
	wire  logic        accept = req & wait_q;
	wire  logic        wr_fire = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
	wire  logic [7:0]  idx    = AVS_ADDRESS[9:2];
	wire  logic [7:0]  wbyte  = AVS_WRITEDATA[7:0];
	wire  logic        hit_ctrl = (idx == `PWK_IDX_WAKE_CTRL);
	wire  logic        hit_pend = (idx == `PWK_IDX_WAKE_PEND);
	wire  logic        hit_stat = (idx == `PWK_IDX_SRC_STATUS);
	wire  logic        hit_en   = (idx == `PWK_IDX_SRC_ENABLE);

	// wake state, standby domain
	logic              glob_en_q;
	logic              pend_q;
	pwk_pkg::pwk_byte_t stat_q, en_q;

	// record events regardless of enables; disabled still recorded
	wire  pwk_pkg::pwk_byte_t ev = {3'b000, wk_s2_q} & `PWK_SRC_MASK;
	// write one clears, event set wins over clear
	wire  pwk_pkg::pwk_byte_t stat_clr = (wr_fire & hit_stat) ? (wbyte & `PWK_SRC_MASK)
		: `PWK_RST_BYTE;
	wire  pwk_pkg::pwk_byte_t stat_d = ((stat_q & ~stat_clr) | ev) & `PWK_SRC_MASK;
	// pending set by any enabled event, independent of global enable
	wire  logic        pend_set = |(ev & en_q);
	wire  logic        pend_clr = wr_fire & hit_pend & wbyte[0];
	wire  logic        pend_d   = pend_set | (pend_q & ~pend_clr);
	// drive only with global enable and the next pending value pend_d, so a new enabled event drives in the same edge
	wire  logic        wake_d   = glob_en_q & pend_d;

	always_ff @(posedge SYS_CLK or negedge srst_n) begin
		if (!srst_n) begin
			glob_en_q <= 1'b0;
			pend_q    <= 1'b0;
			stat_q    <= `PWK_RST_BYTE;
			en_q      <= `PWK_RST_BYTE;
		end else begin
			pend_q <= pend_d;
			stat_q <= stat_d;
			if (wr_fire && hit_ctrl) begin
				glob_en_q <= wbyte[0];
			end
			if (wr_fire && hit_en) begin
				en_q <= wbyte & `PWK_SRC_MASK;
			end
		end
	end

	// outputs of the wake path, open drain style
	always_ff @(posedge SYS_CLK or negedge srst_n) begin
		if (!srst_n) begin
			WAKE_REQUEST_N  <= 1'b1;
			WAKE_REQUEST_OE <= 1'b0;
			IRQ             <= 1'b0;
		end else begin
			// released pin when global enable is zero
			WAKE_REQUEST_N  <= ~wake_d;
			WAKE_REQUEST_OE <= wake_d;
			IRQ             <= |(stat_d & en_q);
		end
	end

	// read mux; shadows with reserved bits as zero
	wire  pwk_pkg::pwk_byte_t rmux =
		(idx == `PWK_IDX_FDD_RATE)  ? (FDD_RATE_CTRL & `PWK_FDD_RATE_MASK) :
		(idx == `PWK_IDX_SER1_FIFO) ? (SER1_FIFO_CTRL & `PWK_SER_FIFO_MASK) :
		(idx == `PWK_IDX_SER2_FIFO) ? (SER2_FIFO_CTRL & `PWK_SER_FIFO_MASK) :
		hit_ctrl ? {7'h00, glob_en_q} :
		hit_pend ? {7'h00, pend_q} :
		hit_stat ? stat_q :
		hit_en   ? en_q : `PWK_RST_BYTE;

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= `PWK_RST_WORD;
		end else begin
			wait_q <= ~accept;
			if (accept && AVS_READ) begin
				rdata_q <= {24'h000000, rmux};
			end
		end
	end

	assign AVS_WAITREQUEST = wait_q;
	assign AVS_READDATA    = rdata_q;
endmodule

// ==== tb/pwk_properties.sv ====
// port properties of the wake block
`timescale 1ns/1ps
module pwk_properties (
	input wire logic	SYS_CLK,
	input wire logic	NRST,
	input wire logic	STBY_NRST,
	input wire logic	AVS_READ,
	input wire logic	AVS_WRITE,
	input wire logic	AVS_WAITREQUEST,
	input wire logic	PORT1_RING_WAKE,
	input wire logic	PORT2_RING_WAKE,
	input wire logic	KEYBOARD_WAKE,
	input wire logic	MOUSE_WAKE,
	input wire logic	WAKE_REQUEST_N,
	input wire logic	WAKE_REQUEST_OE,
	input wire logic	IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST || !STBY_NRST);
	// pins held two cycles, so depth 3 hits either sync latency
	wire any_wake = PORT1_RING_WAKE | PORT2_RING_WAKE | KEYBOARD_WAKE | MOUSE_WAKE;
	property p_wt_pulse; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	a_wt_pulse: assert property (p_wt_pulse) else $error("wait low too long");
	property p_wt_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	a_wt_ans: assert property (p_wt_ans) else $error("no answer");
	property p_oe; WAKE_REQUEST_OE != WAKE_REQUEST_N; endproperty
	a_oe: assert property (p_oe) else $error("oe mismatch");
	// register writes act one edge after the request is first seen, then the flop follows
	property p_irq_up; $rose(IRQ) |-> $past(any_wake, 3) || $past(AVS_WRITE, 2); endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq without cause");
	property p_req_up; $fell(WAKE_REQUEST_N) |-> $past(any_wake, 3) || $past(AVS_WRITE, 2); endproperty
	a_req_up: assert property (p_req_up) else $error("request without cause");
	property p_irq_hold; IRQ && !AVS_WRITE |=> IRQ; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
	property p_req_hold; !WAKE_REQUEST_N && !AVS_WRITE |=> !WAKE_REQUEST_N; endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_req_rel; $rose(WAKE_REQUEST_N) |-> $past(AVS_WRITE, 2); endproperty
	a_req_rel: assert property (p_req_rel) else $error("release without write");
endmodule
bind pwk_top pwk_properties pwk_properties_inst (.*);

// ==== tb/pwk_host_model.sv ====
// host wake input with its pull-up
`timescale 1ns/1ps
module pwk_host_model (
	input wire logic	WAKE_REQUEST_N,
	input wire logic	WAKE_REQUEST_OE,
	output logic	pme_n
);
	// released line rests high via pull-up
	assign pme_n = (WAKE_REQUEST_OE && !WAKE_REQUEST_N) ? 1'b0 : 1'b1;
endmodule

// ==== tb/tb.sv ====
// wake block bench
`timescale 1ns/1ps
`include "pwk_cfg.svh"
module tb;
	logic	clk = 0, nrst = 0, snrst = 0, rd = 0, wr = 0, wt, wn, oe, irq, pme_n;
	logic [9:0]	adr = 0;
	logic [31:0]	wd = 0, rdat;
	logic [7:0]	fdd = 0, s1 = 0, s2 = 0, q, en, g;
	logic [4:1]	src = 0;
	int	err_count = 0, tests_run = 0;
	always #4 clk = ~clk;
	pwk_top pwk_top_inst (.SYS_CLK(clk), .NRST(nrst), .STBY_NRST(snrst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .FDD_RATE_CTRL(fdd), .SER1_FIFO_CTRL(s1),
		.SER2_FIFO_CTRL(s2), .PORT1_RING_WAKE(src[2]), .PORT2_RING_WAKE(src[1]),
		.KEYBOARD_WAKE(src[3]), .MOUSE_WAKE(src[4]), .WAKE_REQUEST_N(wn),
		.WAKE_REQUEST_OE(oe), .IRQ(irq));
	pwk_host_model pwk_host_model_inst (.WAKE_REQUEST_N(wn), .WAKE_REQUEST_OE(oe), .pme_n(pme_n));
	task chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %0t saw %h want %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] i, d);
		@(posedge clk);
		adr <= {i, 2'b00};
		wr <= w;
		rd <= !w;
		wd <= {24'h0, d};
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat[7:0];
		rd <= 0;
		wr <= 0;
	endtask
	function logic [7:0] sbit(input int i, input logic on);
		return on ? 8'h01 << i : 8'h00;
	endfunction
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		print_verdict;
	end
	initial begin
		void'($urandom(2594));
		repeat (20) @(posedge clk);
		nrst <= 1;
		snrst <= 1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			bus(0, 8'hC5 + i[7:0], 0);
			chk(q, 0);
		end
		fdd <= $urandom;
		s1 <= $urandom;
		s2 <= $urandom;
		bus(1, 8'hC2, 8'hFF);
		bus(0, 8'hC2, 0);
		chk(q, fdd & `PWK_FDD_RATE_MASK);
		bus(0, 8'hC3, 0);
		chk(q, s1 & `PWK_SER_FIFO_MASK);
		bus(0, 8'hC4, 0);
		chk(q, s2 & `PWK_SER_FIFO_MASK);
		$display("registers done");
		for (int i = 1; i < 5; i++) begin
			en = $urandom;
			g = $urandom;
			// every enable pairing is visited
			en[i] = i[0];
			g[0] = i[1];
			bus(1, 8'hC8, en);
			bus(1, 8'hC5, g);
			src[i] <= 1;
			repeat (2) @(posedge clk);
			src[i] <= 0;
			repeat (6) @(posedge clk);
			nrst <= 0;
			@(posedge clk);
			nrst <= 1;
			repeat (3) @(posedge clk);
			bus(0, 8'hC7, 0);
			chk(q, sbit(i, 1));
			chk(irq, en[i]);
			chk(pme_n, !(en[i] & g[0]));
			bus(0, 8'hC5, 0);
			chk(q, g & `PWK_CTRL_MASK);
			bus(0, 8'hC8, 0);
			chk(q, en & `PWK_SRC_MASK);
			bus(1, 8'hC7, ~sbit(i, 1));
			bus(1, 8'hC6, 0);
			bus(0, 8'hC6, 0);
			chk(q, sbit(0, en[i]));
			chk(pme_n, !(en[i] & g[0]));
			bus(1, 8'hC7, 8'hFF);
			bus(1, 8'hC6, 8'h01);
			bus(0, 8'hC7, 0);
			chk(q, 0);
			chk(pme_n, 1);
			$display("source %0d done", i);
		end
		print_verdict;
	end
endmodule
